// ---- tsi_pkg.sv ----
// Constants for the timer status, interrupt and low-power block.
// Assumes a 32-bit APB bus with byte addresses on aligned words.
package tsi_pkg;
  localparam int CH_COUNT = 6;
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNTER        = 8'h04;
  localparam logic [7:0] OFS_MODULO         = 8'h08;
  localparam logic [7:0] OFS_CHANNEL_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_CHANNEL_BASE   = 8'h10;
  localparam logic [7:0] OFS_CHANNEL_LAST   = 8'h24;
  // Status and control field positions.
  localparam int BIT_OVF       = 7;
  localparam int BIT_OVF_IE    = 6;
  localparam int BIT_HALT      = 5;
  localparam int BIT_CLEAR     = 4;
  localparam int PS_LSB        = 0;
  // Channel control field positions.
  localparam int CH_FLAG_LSB   = 0;
  localparam int CH_IE_LSB     = 8;
  localparam int CH_OC_LSB     = 16;
  localparam int CH_BUF_LSB    = 24;
  // Values after reset and fixed codes.
  localparam logic [2:0]  PS_EXTERNAL  = 3'h7;
  localparam logic [2:0]  PS_RESET     = 3'h0;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic        HALT_RESET   = 1'b1;
endpackage : tsi_pkg

// ---- tsi_prescaler.sv ----
// Prescaler for the timer counter: a bus clock divider or an external clock edge.
// Assumes the external edge is already synchronised to core_clk.
module tsi_prescaler
  import tsi_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Control.
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  input  wire logic       ext_rise,
  // Counter tick.
  output logic            tick
);
  typedef struct packed {
    logic [5:0] div;
  } tsi_pre_state_type;

  tsi_pre_state_type st;
  tsi_pre_state_type next_st;
  logic [5:0]        mask;

  always_comb
  begin
    mask = 6'(7'(7'h01 << sel) - 7'h01);
    next_st = st;
    if (clear)
    begin
      next_st.div = 6'h00;
    end
    else if (run)
    begin
      next_st.div = st.div + 6'h01;
    end
    // Code 111 hands the counter to the pin, others divide by 2**sel. [R10] [R20] [R22]
    if (sel == PS_EXTERNAL)
    begin
      tick = run & ~clear & ext_rise;
    end
    else
    begin
      tick = run & ~clear & ((st.div & mask) == mask);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : tsi_prescaler

// ---- tsi_top.sv ----
// Six-channel 16-bit timer: status/control, flags, interrupt, low-power and break.
// Assumes an APB master on core_clk and synchronous mode and channel inputs.
//
// Functional notes
// R1: Overflow flag sets on rollover after modulo.
// R2: Overflow interrupt needs flag and enable.
// R3: Channel events set flags; enables gate interrupts.
// R4: Timer runs in wait; interrupts wake.
// R5: Registers inaccessible while in wait mode.
// R6: Stop mode freezes timer, keeps state.
// R7: Break halts the counter.
// R8: Break protects flags unless clear enable set.
// R9: Armed clear survives break, completes after.
// R10: Prescale code all ones selects pin.
// R11: External clock below 4 MHz, half bus.
// R12: Selected clock pin is forced input.
// R13: Channels capture or compare; even ones buffer.
// R14: Flag clears by read then write zero.
// R15: Reset clears flag, sets counter halt.
// R16: Halt suppresses input captures.
// R17: Counter clear zeroes counter, prescaler, self-clears.
// R18: Keep halt clear when wait wakeup needed.
// R19: Halt timer before wait to save power.
// R20: Prescale codes divide by one through 64.
// R21: Halt with clear stops at zero.
// R22: Pin clock synchronised; counter steps per tick.
module tsi_top
  import tsi_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // System state.
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        break_active,
  input  wire logic        break_clear_enable,
  // External clock pin.
  input  wire logic        external_timer_clock,
  input  wire logic        port_d_direction_bit6,
  output logic             ext_pin_oe,
  // Channel pins.
  input  wire logic [5:0]  ch_in,
  output logic [5:0]       ch_out,
  output logic [5:0]       ch_oe,
  // Interrupt requests.
  output logic             overflow_irq,
  output logic             channel_irq
);
  typedef struct packed {
    logic              overflow_flag;
    logic              overflow_irq_enable;
    logic              counter_halt;
    logic [2:0]        prescale_select;
    logic              ovf_arm;
    logic [15:0]       count;
    logic [15:0]       modulo;
    logic [5:0]        channel_event_flag;
    logic [5:0]        ch_arm;
    logic [5:0]        channel_irq_enable;
    logic [5:0]        ch_compare;
    logic [2:0]        ch_buffered;
    logic [5:0][15:0]  ch_val;
    logic [2:0][15:0]  ch_pend;
    logic [5:0]        ch_in_q;
    logic [5:0]        ch_out;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_s3;
    logic              clear_req;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              overflow_irq;
    logic              channel_irq;
    logic              ext_pin_oe;
  } tsi_state_type;

  tsi_state_type st;
  tsi_state_type next_st;
  logic          tick;
  logic          run;
  logic          flag_clear_ok;
  logic          access;
  logic          finish;
  logic          rollover;
  logic [31:0]   rd;
  logic          mapped;
  int            idx;

  function automatic logic is_channel(input logic [7:0] a);
    return (a >= OFS_CHANNEL_BASE) && (a <= OFS_CHANNEL_LAST) && (a[1:0] == 2'b00);
  endfunction : is_channel

  function automatic int channel_of(input logic [7:0] a);
    return int'((a - OFS_CHANNEL_BASE) >> 2);
  endfunction : channel_of

  // Counter advances outside stop, break and halt; clear request zeroes the divider.
  assign run = ~st.counter_halt & ~stop_mode & ~break_active; // [R6] [R7] [R15]

  tsi_prescaler u_pre (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (st.clear_req),
    .run      (run),
    .sel      (st.prescale_select),
    .ext_rise (st.ext_s2 & ~st.ext_s3),
    .tick     (tick)
  );

  always_comb
  begin
    next_st = st;
    idx = 0;
    access = psel & penable;
    finish = access & st.pready;
    // During break a clear only goes through when software was allowed it.
    flag_clear_ok = ~break_active | break_clear_enable; // [R8] [R9]
    rollover = tick & ~st.clear_req & (st.count == st.modulo);

    // Synchroniser: the second and third stages feed the edge detector. [R22]
    next_st.ext_s1 = external_timer_clock;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_s3 = st.ext_s2;
    next_st.ch_in_q = ch_in;

    // Read mux, valid one cycle into the access phase.
    rd = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == OFS_STATUS_CONTROL)
    begin
      rd[BIT_OVF] = st.overflow_flag;
      rd[BIT_OVF_IE] = st.overflow_irq_enable;
      rd[BIT_HALT] = st.counter_halt;
      rd[PS_LSB +: 3] = st.prescale_select; // Clear bit always reads as zero. [R17]
    end
    else if (paddr == OFS_COUNTER)
    begin
      rd[15:0] = st.count;
    end
    else if (paddr == OFS_MODULO)
    begin
      rd[15:0] = st.modulo;
    end
    else if (paddr == OFS_CHANNEL_CTRL)
    begin
      rd[CH_FLAG_LSB +: 6] = st.channel_event_flag;
      rd[CH_IE_LSB +: 6] = st.channel_irq_enable;
      rd[CH_OC_LSB +: 6] = st.ch_compare;
      for (int k = 0; k < 3; k++)
      begin
        rd[CH_BUF_LSB + 2 * k] = st.ch_buffered[k];
      end
    end
    else if (is_channel(paddr))
    begin
      rd[15:0] = st.ch_val[channel_of(paddr)];
    end
    else
    begin
      mapped = 1'b0;
    end

    // Two-phase APB answer: ready one cycle into the access phase.
    next_st.pready = access & ~st.pready;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    if (access & ~st.pready)
    begin
      // Registers are closed to the CPU while it sleeps in wait. [R5]
      next_st.pslverr = ~mapped | wait_mode;
      next_st.prdata = (mapped & ~wait_mode) ? rd : 32'h0000_0000;
    end

    // Counter clear is a one-cycle request that never persists. [R17]
    next_st.clear_req = 1'b0;

    // Effects at the completing edge of a transfer.
    if (finish & ~st.pslverr)
    begin
      if (!pwrite)
      begin
        if (paddr == OFS_STATUS_CONTROL && st.overflow_flag && flag_clear_ok)
        begin
          next_st.ovf_arm = 1'b1; // [R14] [R8]
        end
        if (paddr == OFS_CHANNEL_CTRL && flag_clear_ok)
        begin
          next_st.ch_arm = st.ch_arm | st.channel_event_flag;
        end
      end
      else if (paddr == OFS_STATUS_CONTROL)
      begin
        next_st.overflow_irq_enable = pwdata[BIT_OVF_IE];
        next_st.counter_halt = pwdata[BIT_HALT];
        next_st.prescale_select = pwdata[PS_LSB +: 3];
        next_st.clear_req = pwdata[BIT_CLEAR]; // [R17] [R21]
        // Only a zero write after an armed read clears; a one does nothing. [R14] [R9]
        if (!pwdata[BIT_OVF] && st.ovf_arm && flag_clear_ok)
        begin
          next_st.overflow_flag = 1'b0;
          next_st.ovf_arm = 1'b0;
        end
      end
      else if (paddr == OFS_MODULO)
      begin
        next_st.modulo = pwdata[15:0];
      end
      else if (paddr == OFS_CHANNEL_CTRL)
      begin
        next_st.channel_irq_enable = pwdata[CH_IE_LSB +: 6];
        next_st.ch_compare = pwdata[CH_OC_LSB +: 6]; // [R13]
        for (int k = 0; k < 3; k++)
        begin
          next_st.ch_buffered[k] = pwdata[CH_BUF_LSB + 2 * k];
        end
        if (flag_clear_ok)
        begin
          for (int k = 0; k < CH_COUNT; k++)
          begin
            if (!pwdata[CH_FLAG_LSB + k] && st.ch_arm[k])
            begin
              next_st.channel_event_flag[k] = 1'b0; // [R14] [R3]
              next_st.ch_arm[k] = 1'b0;
            end
          end
        end
      end
      else if (is_channel(paddr))
      begin
        idx = channel_of(paddr);
        // Even channels in buffered mode load their compare at the next rollover. [R13]
        if (idx % 2 == 0 && st.ch_buffered[idx / 2])
        begin
          next_st.ch_pend[idx / 2] = pwdata[15:0];
        end
        else
        begin
          next_st.ch_val[idx] = pwdata[15:0];
        end
      end
    end

    // Counter: clear beats a tick, and with halt set the count rests at zero. [R21]
    if (st.clear_req)
    begin
      next_st.count = COUNT_RESET; // [R17]
    end
    else if (tick)
    begin
      next_st.count = rollover ? COUNT_RESET : st.count + 16'h0001; // [R22]
    end

    // A new overflow wins over a clear in the same cycle and cancels the armed read. [R1] [R14]
    if (rollover)
    begin
      next_st.overflow_flag = 1'b1;
      next_st.ovf_arm = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
        if (st.ch_buffered[k])
        begin
          next_st.ch_val[2 * k] = st.ch_pend[k];
        end
      end
    end

    // Channel events set flags after any clear, so the event is never lost. [R3]
    for (int k = 0; k < CH_COUNT; k++)
    begin
      if (!st.ch_compare[k])
      begin
        // Captures are dropped during halt and stop. [R16] [R6]
        if (ch_in[k] && !st.ch_in_q[k] && run)
        begin
          next_st.ch_val[k] = st.count;
          next_st.channel_event_flag[k] = 1'b1;
          next_st.ch_arm[k] = 1'b0;
        end
      end
      else if (tick && st.count == st.ch_val[k])
      begin
        next_st.ch_out[k] = ~st.ch_out[k];
        next_st.channel_event_flag[k] = 1'b1;
        next_st.ch_arm[k] = 1'b0;
      end
    end

    // Requests stay live in wait so they can wake the processor. [R2] [R3] [R4]
    next_st.overflow_irq = next_st.overflow_flag & next_st.overflow_irq_enable;
    next_st.channel_irq = |(next_st.channel_event_flag & next_st.channel_irq_enable);
    // The pin only drives as an output when it is not the clock source. [R12]
    next_st.ext_pin_oe = port_d_direction_bit6 & (next_st.prescale_select != PS_EXTERNAL);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.counter_halt <= HALT_RESET; // [R15]
      st.prescale_select <= PS_RESET; // [R20]
      st.modulo <= MODULO_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign ext_pin_oe   = st.ext_pin_oe;
  assign ch_out       = st.ch_out;
  assign ch_oe        = st.ch_compare;
  assign overflow_irq = st.overflow_irq;
  assign channel_irq  = st.channel_irq;
endmodule : tsi_top

// ---- tsi_top_asserts.sv ----
// Checker for the timer status block: bus answers, refusals, status reads and pin enable.
// Assumes it is bound into tsi_top and sees that module's ports only.
module tsi_top_asserts
  import tsi_pkg::*;
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // System state, pin and request.
  input wire logic        wait_mode,
  input wire logic        port_d_direction_bit6,
  input wire logic        ext_pin_oe,
  input wire logic        overflow_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_stat_rd;
    pready && !pwrite && !pslverr && paddr == OFS_STATUS_CONTROL;
  endsequence
  property p_answer;
    s_acc |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_req;
    pready |-> psel && penable;
  endproperty
  property p_wait;
    s_acc ##0 wait_mode |=> pslverr;
  endproperty
  property p_unmap;
    s_acc ##0 paddr > OFS_CHANNEL_LAST |=> pslverr;
  endproperty
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  property p_clr_rd;
    s_stat_rd |-> prdata[31:8] == 24'h0 && !prdata[BIT_CLEAR];
  endproperty
  // A stable request level shows the same flag and enable that the read returns.
  property p_irq;
    s_stat_rd ##0 $stable(overflow_irq) |->
      overflow_irq == (prdata[BIT_OVF] && prdata[BIT_OVF_IE]);
  endproperty
  property p_oe;
    ext_pin_oe |-> $past(port_d_direction_bit6);
  endproperty
  a_answer: assert property (p_answer)
    else $error("Access not answered.");
  a_pulse: assert property (p_pulse)
    else $error("Ready held too long.");
  a_req: assert property (p_req)
    else $error("Ready without request.");
  a_wait: assert property (p_wait)
    else $error("Access in wait not refused.");
  a_unmap: assert property (p_unmap)
    else $error("Unmapped access not refused.");
  a_err: assert property (p_err)
    else $error("Refusal carries data.");
  a_clr_rd: assert property (p_clr_rd)
    else $error("Clear bit reads one.");
  a_irq: assert property (p_irq)
    else $error("Overflow request mismatch.");
  a_oe: assert property (p_oe)
    else $error("Pin driven without direction.");
endmodule : tsi_top_asserts

bind tsi_top tsi_top_asserts u_asserts (.*);

// ---- tsi_ext_clk.sv ----
// Model of the external source that drives the timer clock pin.
// Assumes the bench enables it only while counting on the pin is wanted.
module tsi_ext_clk
(
  // Control.
  input  wire logic en,
  // Clock pin.
  output logic      clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A 250 ns period stays at 4 MHz and below half the bus rate.
  initial clk_out = 1'b0;
  always
  begin
    wait (en);
    #125 clk_out = 1'b1;
    #125 clk_out = 1'b0;
  end
endmodule : tsi_ext_clk

// ---- timer_status_interrupt_lowpower_tb.sv ----
// Self-checking bench for the timer status block over APB.
// Assumes tsi_top, its checker and the clock source model are compiled first.
module timer_status_interrupt_lowpower_tb
  import tsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel, penable, pwrite, wait_mode, stop_mode, break_active;
  logic        break_clear_enable, port_d_direction_bit6, ext_en, external_timer_clock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  ch_in, ch_out, ch_oe;
  logic        pready, pslverr, ext_pin_oe, overflow_irq, channel_irq;
  logic [15:0] rnd;
  logic [32:0] exp_q[$];
  int          bad_count = 0;
  int          tests_run = 0;
  int          seed = 78;

  always #10 core_clk = ~core_clk;

  tsi_top DUT (
    .core_clk              (core_clk),
    .arst_n                (arst_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .wait_mode             (wait_mode),
    .stop_mode             (stop_mode),
    .break_active          (break_active),
    .break_clear_enable    (break_clear_enable),
    .external_timer_clock  (external_timer_clock),
    .port_d_direction_bit6 (port_d_direction_bit6),
    .ext_pin_oe            (ext_pin_oe),
    .ch_in                 (ch_in),
    .ch_out                (ch_out),
    .ch_oe                 (ch_oe),
    .overflow_irq          (overflow_irq),
    .channel_irq           (channel_irq)
  );
  tsi_ext_clk XCLK (.en(ext_en), .clk_out(external_timer_clock));

  task check(input logic [32:0] got, input logic [32:0] want);
    tests_run++;
    if (got !== want)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      bad_count++;
      stop_test();
    end
  endtask : xfer

  task rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // The oldest note is compared with each read answer, refusal bit on top.
  always @(posedge core_clk)
    if (pready === 1'b1 && pwrite === 1'b0)
      check({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'bx);

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ch_in, wait_mode, stop_mode, break_active,
     break_clear_enable, port_d_direction_bit6, ext_en} = '0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(OFS_STATUS_CONTROL, 33'h20);
    rd(OFS_MODULO, 33'hffff);
    ch_in <= 6'h3f;
    repeat (3) @(posedge core_clk);
    rd(OFS_CHANNEL_CTRL, 33'h0);
    ch_in <= 6'h00;
    rnd = 16'($random(seed));
    xfer(1'b1, OFS_MODULO, {16'h0, rnd});
    rd(OFS_MODULO, {17'h0, rnd});
    $display("Test reset done");
    xfer(1'b1, OFS_MODULO, 32'h3);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h40);
    ch_in <= 6'h3f;
    repeat (8) @(posedge core_clk);
    check(33'(overflow_irq), 33'h1);
    rd(OFS_CHANNEL_CTRL, 33'h3f);
    check(33'(channel_irq), 33'h0);
    xfer(1'b1, OFS_CHANNEL_CTRL, 32'h3f3f);
    repeat (3) @(posedge core_clk);
    check(33'(channel_irq), 33'h1);
    // A rollover lands between this read and the write, so the flag stays.
    rd(OFS_STATUS_CONTROL, 33'hc0);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h70);
    rd(OFS_COUNTER, 33'h0);
    rd(OFS_STATUS_CONTROL, 33'he0);
    break_active <= 1'b1;
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h60);
    rd(OFS_STATUS_CONTROL, 33'he0);
    break_active <= 1'b0;
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h60);
    rd(OFS_STATUS_CONTROL, 33'h60);
    check(33'(overflow_irq), 33'h0);
    $display("Test flags done");
    break_active <= 1'b1;
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h00);
    repeat (10) @(posedge core_clk);
    rd(OFS_COUNTER, 33'h0);
    break_active <= 1'b0;
    stop_mode <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(OFS_COUNTER, 33'h0);
    rd(OFS_MODULO, 33'h3);
    stop_mode <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(OFS_STATUS_CONTROL, 33'h80);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h40);
    wait_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(33'(overflow_irq), 33'h1);
    rd(OFS_STATUS_CONTROL, 33'h100000000);
    wait_mode <= 1'b0;
    rd(8'h40, 33'h100000000);
    // Halting before wait saves power, so the count must not move while asleep.
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h30);
    wait_mode <= 1'b1;
    repeat (10) @(posedge core_clk);
    wait_mode <= 1'b0;
    rd(OFS_COUNTER, 33'h0);
    break_active <= 1'b1;
    break_clear_enable <= 1'b1;
    rd(OFS_STATUS_CONTROL, 33'ha0);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h20);
    break_active <= 1'b0;
    break_clear_enable <= 1'b0;
    rd(OFS_STATUS_CONTROL, 33'h20);
    $display("Test modes done");
    xfer(1'b1, OFS_MODULO, 32'h8);
    for (int p = 0; p < 7; p++)
    begin
      xfer(1'b1, OFS_STATUS_CONTROL, 32'h30 + 32'(p));
      rd(OFS_STATUS_CONTROL, 33'h20 + 33'(p));
      for (int k = 0; k < 2; k++)
      begin
        xfer(1'b1, OFS_STATUS_CONTROL, 32'(p));
        repeat ((6 << p) - 3) @(posedge core_clk);
        xfer(1'b1, OFS_STATUS_CONTROL, 32'h20 + 32'(p));
        rd(OFS_STATUS_CONTROL, (k == 0 ? 33'h20 : 33'ha0) + 33'(p));
      end
    end
    $display("Test prescaler done");
    port_d_direction_bit6 <= 1'b1;
    xfer(1'b1, OFS_MODULO, 32'hffff);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h30);
    repeat (2) @(posedge core_clk);
    check(33'(ext_pin_oe), 33'h1);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h27);
    repeat (2) @(posedge core_clk);
    check(33'(ext_pin_oe), 33'h0);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h07);
    ext_en <= 1'b1;
    repeat (45) @(posedge core_clk);
    ext_en <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(OFS_COUNTER, 33'h4);
    // Channel 1 turns to compare and toggles when the count reaches six.
    xfer(1'b1, OFS_CHANNEL_CTRL, 32'h0002_0000);
    xfer(1'b1, OFS_CHANNEL_BASE + 8'h04, 32'h6);
    repeat (2) @(posedge core_clk);
    check(33'(ch_oe), 33'h02);
    check(33'(ch_out), 33'h00);
    xfer(1'b1, OFS_STATUS_CONTROL, 32'h00);
    repeat (4) @(posedge core_clk);
    check(33'(ch_out), 33'h02);
    rd(OFS_CHANNEL_CTRL, 33'h20002);
    $display("Test compare done");
    $display("Test pin clock done");
    stop_test();
  end
endmodule : timer_status_interrupt_lowpower_tb
